// ### hdl/ccrb_pkg.sv
package ccrb_pkg;

   localparam logic [15:0] ADDR_RESET = 16'h0001;
   localparam logic [15:0] ADDR_BCAST = 16'h0000;
   localparam logic [15:0] DRV_RESET  = 16'h0404;

   // Extended configuration array byte indices
   localparam logic [8:0] IDX_ERASE_GRP  = 9'h0af;
   localparam logic [8:0] IDX_BOOT_W     = 9'h0b1;
   localparam logic [8:0] IDX_BOOT       = 9'h0b3;
   localparam logic [8:0] IDX_ERASED     = 9'h0b5;
   localparam logic [8:0] IDX_WIDTH      = 9'h0b7;
   localparam logic [8:0] IDX_FAST       = 9'h0b9;
   localparam logic [8:0] IDX_POWER      = 9'h0bb;
   localparam logic [8:0] IDX_CMD_REV    = 9'h0bd;
   localparam logic [8:0] IDX_CMD_GRP    = 9'h0bf;
   localparam logic [8:0] IDX_REV        = 9'h0c0;
   localparam logic [8:0] MODES_TOP      = 9'h0c0;
   localparam logic [8:0] IDX_STRUCT_VER = 9'h0c2;
   localparam logic [8:0] IDX_CARD_TYPE  = 9'h0c4;
   localparam logic [8:0] IDX_PERF_LO    = 9'h0cd;
   localparam logic [8:0] IDX_PERF_HI    = 9'h0d2;
   localparam logic [8:0] IDX_REL_WR     = 9'h0de;
   localparam logic [8:0] IDX_BOOT_INFO  = 9'h0e4;

   // Fixed byte values and reset values
   localparam logic [7:0] REV_VALUE     = 8'h02;
   localparam logic [7:0] CMD_REV_VALUE = 8'h00;
   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] WIDTH_RESET   = 8'h02;
   localparam logic [7:0] STRUCT_VER    = 8'h02;
   localparam logic [7:0] CARD_TYPE     = 8'h03;
   localparam logic [7:0] PERF_VALUE    = 8'h08;
   localparam logic [7:0] REL_WR_VALUE  = 8'h01;
   localparam logic [7:0] BOOT_INFO     = 8'h01;

   // Host-writable mode bytes, slot order
   localparam int          NUM_RW = 7;
   localparam int          WIDTH_SLOT = 3;
   localparam logic [8:0]  RW_IDX [NUM_RW] = '{IDX_CMD_GRP, IDX_POWER, IDX_FAST,
      IDX_WIDTH, IDX_BOOT, IDX_BOOT_W, IDX_ERASE_GRP};
   localparam logic [7:0]  RW_RST [NUM_RW] = '{MODE_RESET, MODE_RESET, MODE_RESET,
      WIDTH_RESET, MODE_RESET, MODE_RESET, MODE_RESET};

   // Status word fields
   localparam int ST_OUT_OF_RANGE = 31;
   localparam int ST_ILLEGAL      = 22;
   localparam int ST_SWITCH_ERR   = 7;
   localparam int ST_STATE_LSB    = 9;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_STBY = 4'h3,
      ST_TRAN = 4'h4
   } ccrb_state_e;

   typedef enum logic [2:0] {
      OP_ASSIGN      = 3'h0,
      OP_SELECT      = 3'h1,
      OP_SWITCH      = 3'h2,
      OP_SET_DRV     = 3'h3,
      OP_READ_BYTE   = 3'h4,
      OP_SEND_STATUS = 3'h5
   } ccrb_op_e;

   function automatic logic writable(input logic [8:0] idx);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_RW; i++) begin
         if (idx == RW_IDX[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

endpackage

// ### hdl/ccrb_arr_if.sv
`timescale 1ns/1ps
interface ccrb_arr_if;
   logic       wr_en;
   logic [8:0] wr_idx;
   logic [7:0] wr_data;
   logic [8:0] rd_idx;
   logic [7:0] rd_data;
   logic [7:0] fast_timing;
   logic [7:0] erase_group;
   logic [7:0] data_width;
   modport ctl (output wr_en, wr_idx, wr_data, rd_idx,
                input rd_data, fast_timing, erase_group, data_width);
   modport mem (input wr_en, wr_idx, wr_data, rd_idx,
                output rd_data, fast_timing, erase_group, data_width);
endinterface

// ### hdl/ccrb_xarray.sv
`timescale 1ns/1ps
module ccrb_xarray #(
   // Arbitrary default
   parameter logic [7:0] ERASED_VALUE = 8'h00
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Array port
   ccrb_arr_if.mem  arr
);

   logic [7:0] mode_q [ccrb_pkg::NUM_RW];
   logic [7:0] rd_data_q;

   for (genvar i = 0; i < ccrb_pkg::NUM_RW; i++) begin : g_mode
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            mode_q[i] <= ccrb_pkg::RW_RST[i];
         end else if (arr.wr_en && arr.wr_idx == ccrb_pkg::RW_IDX[i]) begin
            mode_q[i] <= arr.wr_data;
         end
      end
   end

   function automatic logic [7:0] byte_at(input logic [8:0] idx);
      logic [7:0] v;
      v = 8'h00;
      for (int i = 0; i < ccrb_pkg::NUM_RW; i++) begin
         if (idx == ccrb_pkg::RW_IDX[i] && i != ccrb_pkg::WIDTH_SLOT) begin
            v = mode_q[i];
         end
      end
      if (idx == ccrb_pkg::IDX_REV) v = ccrb_pkg::REV_VALUE;
      if (idx == ccrb_pkg::IDX_CMD_REV) v = ccrb_pkg::CMD_REV_VALUE;
      if (idx == ccrb_pkg::IDX_ERASED) v = ERASED_VALUE;
      if (idx == ccrb_pkg::IDX_STRUCT_VER) v = ccrb_pkg::STRUCT_VER;
      if (idx == ccrb_pkg::IDX_CARD_TYPE) v = ccrb_pkg::CARD_TYPE;
      if (idx >= ccrb_pkg::IDX_PERF_LO && idx <= ccrb_pkg::IDX_PERF_HI) begin
         v = ccrb_pkg::PERF_VALUE;
      end
      if (idx == ccrb_pkg::IDX_REL_WR) v = ccrb_pkg::REL_WR_VALUE;
      if (idx == ccrb_pkg::IDX_BOOT_INFO) v = ccrb_pkg::BOOT_INFO;
      return v;
   endfunction

   // Registered read, reserved bytes give zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= byte_at(arr.rd_idx);
      end
   end

   assign arr.rd_data     = rd_data_q;
   assign arr.fast_timing = mode_q[2];
   assign arr.data_width  = mode_q[ccrb_pkg::WIDTH_SLOT];
   assign arr.erase_group = mode_q[6];

endmodule

// ### hdl/ccrb_top.sv
// What this block does
// - Holds a writable 16-bit relative address, loaded during identification.
// - After identification, addressed commands act only when their address matches, except a select, which parks the device on a mismatch.
// - Relative address resets to 0x0001 until the host assigns another.
// - Address 0x0000 is never assigned; selecting it after identification puts the device in standby.
// - 16-bit driver stage register, reset 0x404, optionally written by host.
// - Card config tells the host whether the driver stage register exists.
// - Status register holds state and last completion code, returned on poll.
// - Reserved configuration bytes read back as zero.
// - Byte 185 selects fast interface timing, read-write, reset zero.
// - Byte 175 selects high-density erase groups, read-write, reset zero.
// - Mode bytes change only through the switch command, on the addressed byte.
// - Array is 512 bytes: upper 320 read-only, lower 192 mode bytes.
`timescale 1ns/1ps
module ccrb_top #(
   parameter logic       DRV_IMPL     = 1'b1,
   // Arbitrary default
   parameter logic [7:0] ERASED_VALUE = 8'h00
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rstn,
   // Decoded host command
   input  wire logic        cmd_valid,
   input  wire logic [2:0]  cmd_op,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [8:0]  cmd_index,
   input  wire logic [7:0]  cmd_value,
   input  wire logic [15:0] cmd_drv,
   // Response
   output logic             resp_valid,
   output logic [31:0]      resp_data,
   // Settings seen by the rest of the device
   output logic [15:0]      relative_bus_address,
   output logic [15:0]      driver_stage_setting,
   output logic             drv_present,
   output logic [7:0]       fast_timing_select,
   output logic [7:0]       erase_group_select,
   output logic [7:0]       data_width_select,
   output logic [3:0]       card_state
);

   ////////////////////////////////////////////////////////////////////////////

   ccrb_arr_if arr ();

   ccrb_xarray #(
      .ERASED_VALUE (ERASED_VALUE)
   ) u_xarray (
      .clock (clock),
      .rstn  (rstn),
      .arr   (arr)
   );

   ccrb_pkg::ccrb_state_e state_q;
   ccrb_pkg::ccrb_op_e    op;
   logic [15:0]           addr_q;
   logic [15:0]           drv_q;
   logic                  ill_q;
   logic                  swe_q;
   logic                  oor_q;
   logic                  p1_q;
   logic                  p1_read_q;
   logic                  resp_valid_q;
   logic [31:0]           resp_data_q;
   logic [31:0]           status_word;
   logic                  addr_hit;
   logic                  addressed;
   logic                  take_assign;
   logic                  take_addr;
   logic                  in_tran;
   logic                  sw_ok;
   logic                  sw_bad;
   logic                  sel_away;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode

   assign op = ccrb_pkg::ccrb_op_e'(cmd_op);

   always_comb begin
      unique case (op)
         ccrb_pkg::OP_SELECT,
         ccrb_pkg::OP_SWITCH,
         ccrb_pkg::OP_READ_BYTE,
         ccrb_pkg::OP_SEND_STATUS: begin
            addressed = 1'b1;
         end
         ccrb_pkg::OP_ASSIGN,
         ccrb_pkg::OP_SET_DRV: begin
            addressed = 1'b0;
         end
         default: begin
            addressed = 1'b0;
         end
      endcase
   end

   assign addr_hit    = (state_q != ccrb_pkg::ST_IDLE) && (cmd_addr == addr_q);
   assign take_assign = cmd_valid && op == ccrb_pkg::OP_ASSIGN
                        && state_q == ccrb_pkg::ST_IDLE;
   assign take_addr   = cmd_valid && addressed && addr_hit;
   assign in_tran     = state_q == ccrb_pkg::ST_TRAN;
   assign sw_ok       = take_addr && op == ccrb_pkg::OP_SWITCH && in_tran
                        && cmd_index < ccrb_pkg::MODES_TOP
                        && ccrb_pkg::writable(cmd_index);
   assign sw_bad      = take_addr && op == ccrb_pkg::OP_SWITCH && in_tran && !sw_ok;
   // A select naming someone else, or the reserved address, parks the device
   assign sel_away    = cmd_valid && op == ccrb_pkg::OP_SELECT
                        && state_q != ccrb_pkg::ST_IDLE && !addr_hit;

   ////////////////////////////////////////////////////////////////////////////
   // Array access

   assign arr.wr_en   = sw_ok;
   assign arr.wr_idx  = cmd_index;
   assign arr.wr_data = cmd_value;
   assign arr.rd_idx  = cmd_index;

   ////////////////////////////////////////////////////////////////////////////
   // Relative address

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         addr_q <= ccrb_pkg::ADDR_RESET;
      end else if (take_assign && cmd_addr != ccrb_pkg::ADDR_BCAST) begin
         addr_q <= cmd_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Driver stage

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         drv_q <= ccrb_pkg::DRV_RESET;
      end else if (cmd_valid && op == ccrb_pkg::OP_SET_DRV && DRV_IMPL) begin
         drv_q <= cmd_drv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Card state

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= ccrb_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            ccrb_pkg::ST_IDLE: begin
               if (take_assign && cmd_addr != ccrb_pkg::ADDR_BCAST) begin
                  state_q <= ccrb_pkg::ST_STBY;
               end
            end
            ccrb_pkg::ST_STBY,
            ccrb_pkg::ST_TRAN: begin
               if (take_addr && op == ccrb_pkg::OP_SELECT) begin
                  state_q <= ccrb_pkg::ST_TRAN;
               end else if (sel_away) begin
                  state_q <= ccrb_pkg::ST_STBY;
               end
            end
            default: begin
               state_q <= ccrb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Completion code of the most recent answered command

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ill_q <= 1'b0;
         swe_q <= 1'b0;
         oor_q <= 1'b0;
      end else if (take_assign || take_addr) begin
         ill_q <= (take_assign && cmd_addr == ccrb_pkg::ADDR_BCAST)
                  || (!in_tran && (op == ccrb_pkg::OP_SWITCH
                                   || op == ccrb_pkg::OP_READ_BYTE));
         swe_q <= sw_bad;
         oor_q <= sw_bad && cmd_index >= ccrb_pkg::MODES_TOP;
      end
   end

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ccrb_pkg::ST_STATE_LSB +: 4] = state_q;
      status_word[ccrb_pkg::ST_ILLEGAL]        = ill_q;
      status_word[ccrb_pkg::ST_SWITCH_ERR]     = swe_q;
      status_word[ccrb_pkg::ST_OUT_OF_RANGE]   = oor_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Response pipeline, answer two edges after the command

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         p1_q      <= 1'b0;
         p1_read_q <= 1'b0;
      end else begin
         p1_q      <= take_assign || take_addr;
         p1_read_q <= take_addr && op == ccrb_pkg::OP_READ_BYTE && in_tran;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         resp_valid_q <= 1'b0;
         resp_data_q  <= 32'h0000_0000;
      end else begin
         resp_valid_q <= p1_q;
         if (p1_q) begin
            resp_data_q <= p1_read_q ? {24'h00_0000, arr.rd_data}
                                     : status_word;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign resp_valid           = resp_valid_q;
   assign resp_data            = resp_data_q;
   assign relative_bus_address = addr_q;
   assign driver_stage_setting = drv_q;
   assign drv_present          = DRV_IMPL;
   assign fast_timing_select   = arr.fast_timing;
   assign erase_group_select   = arr.erase_group;
   assign data_width_select    = arr.data_width;
   assign card_state           = state_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_addr_default;
      state_q == ccrb_pkg::ST_IDLE |-> addr_q == ccrb_pkg::ADDR_RESET;
   endproperty
   a_addr_default: assert property (p_addr_default)
      else $error("address not at default before identification");

   property p_assign;
      take_assign && cmd_addr != ccrb_pkg::ADDR_BCAST
      |=> addr_q == $past(cmd_addr) && state_q == ccrb_pkg::ST_STBY;
   endproperty
   a_assign: assert property (p_assign)
      else $error("assigned address not loaded");

   property p_mismatch;
      cmd_valid && op == ccrb_pkg::OP_SEND_STATUS && !addr_hit
      |=> !p1_q ##1 !resp_valid_q;
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("answered a command for another address");

   property p_bcast;
      cmd_valid && op == ccrb_pkg::OP_SELECT && cmd_addr == ccrb_pkg::ADDR_BCAST
      && state_q != ccrb_pkg::ST_IDLE |=> state_q == ccrb_pkg::ST_STBY;
   endproperty
   a_bcast: assert property (p_bcast)
      else $error("reserved address select did not give standby");

   property p_never_zero;
      addr_q != ccrb_pkg::ADDR_BCAST;
   endproperty
   a_never_zero: assert property (p_never_zero)
      else $error("reserved address was assigned");

   property p_drv;
      cmd_valid && op == ccrb_pkg::OP_SET_DRV && DRV_IMPL |=> drv_q == $past(cmd_drv);
   endproperty
   a_drv: assert property (p_drv)
      else $error("driver stage not written");

   property p_status;
      take_addr && op == ccrb_pkg::OP_SEND_STATUS
      |-> ##2 resp_valid_q
          && resp_data_q[ccrb_pkg::ST_STATE_LSB +: 4] == $past(state_q);
   endproperty
   a_status: assert property (p_status)
      else $error("status poll answer wrong");

   property p_reserved;
      take_addr && op == ccrb_pkg::OP_READ_BYTE && in_tran
      && cmd_index < ccrb_pkg::IDX_ERASE_GRP
      |-> ##2 resp_valid_q && resp_data_q == 32'h0000_0000;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved byte not zero");

   property p_revision;
      take_addr && op == ccrb_pkg::OP_READ_BYTE && in_tran
      && cmd_index == ccrb_pkg::IDX_REV
      |-> ##2 resp_data_q[7:0] == ccrb_pkg::REV_VALUE;
   endproperty
   a_revision: assert property (p_revision)
      else $error("revision byte wrong");

   property p_fast;
      sw_ok && cmd_index == ccrb_pkg::IDX_FAST
      |=> fast_timing_select == $past(cmd_value);
   endproperty
   a_fast: assert property (p_fast)
      else $error("fast timing byte not written");

   property p_erase;
      sw_ok && cmd_index == ccrb_pkg::IDX_ERASE_GRP
      |=> erase_group_select == $past(cmd_value);
   endproperty
   a_erase: assert property (p_erase)
      else $error("erase group byte not written");

   property p_switch_only;
      $changed(fast_timing_select) || $changed(erase_group_select)
      |-> $past(arr.wr_en) && $past(op) == ccrb_pkg::OP_SWITCH;
   endproperty
   a_switch_only: assert property (p_switch_only)
      else $error("mode byte changed without switch");

   property p_ro_keep;
      sw_bad |-> !arr.wr_en ##1 swe_q;
   endproperty
   a_ro_keep: assert property (p_ro_keep)
      else $error("read-only byte write not refused");

   c_assign: cover property (take_assign && cmd_addr != ccrb_pkg::ADDR_BCAST);
   c_select: cover property (take_addr && op == ccrb_pkg::OP_SELECT ##1 in_tran);
   c_fast:   cover property (sw_ok && cmd_index == ccrb_pkg::IDX_FAST);
   c_poll:   cover property (take_addr && op == ccrb_pkg::OP_SEND_STATUS ##2 resp_valid_q);

endmodule

// ### bench/ccrb_host.sv
`timescale 1ns/1ps
module ccrb_host (
   // Clock
   input  wire logic        clock,
   // Command port
   output logic             cmd_valid,
   output logic [2:0]       cmd_op,
   output logic [15:0]      cmd_addr,
   output logic [8:0]       cmd_index,
   output logic [7:0]       cmd_value,
   output logic [15:0]      cmd_drv,
   // Response
   input  wire logic        resp_valid,
   input  wire logic [31:0] resp_data
);

   initial begin
      cmd_valid = 1'b0;
      cmd_op    = 3'h0;
      cmd_addr  = 16'h0000;
      cmd_index = 9'h000;
      cmd_value = 8'h00;
      cmd_drv   = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One command, then watch for its single answer
   task automatic send(input logic [2:0] op, input logic [15:0] addr, input logic [8:0] idx,
                       input logic [7:0] val, input logic [15:0] drv,
                       output logic got, output logic [31:0] data);
      got  = 1'b0;
      data = 32'h0000_0000;
      @(negedge clock);
      cmd_valid = 1'b1;
      cmd_op    = op;
      cmd_addr  = addr;
      cmd_index = idx;
      cmd_value = val;
      cmd_drv   = drv;
      @(negedge clock);
      cmd_valid = 1'b0;
      // Released fields no longer show the last value
      cmd_addr  = ~cmd_addr;
      cmd_index = ~cmd_index;
      cmd_value = ~cmd_value;
      cmd_drv   = ~cmd_drv;
      for (int i = 0; i < 4; i++) begin
         @(negedge clock);
         if (resp_valid === 1'b1 && !got) begin
            got  = 1'b1;
            data = resp_data;
         end
      end
   endtask

endmodule

// ### bench/card_config_register_bank_test.sv
`timescale 1ns/1ps
module card_config_register_bank_test;
   logic        clock;
   logic        rstn;
   logic        cmd_valid;
   logic [2:0]  cmd_op;
   logic [15:0] cmd_addr;
   logic [8:0]  cmd_index;
   logic [7:0]  cmd_value;
   logic [15:0] cmd_drv;
   logic        resp_valid;
   logic [31:0] resp_data;
   logic [15:0] relative_bus_address;
   logic [15:0] driver_stage_setting;
   logic        drv_present;
   logic [7:0]  fast_timing_select;
   logic [7:0]  erase_group_select;
   logic [7:0]  data_width_select;
   logic [3:0]  card_state;
   int          n_fail;
   int          comparisons;
   logic [7:0]  v;
   logic [8:0]  ro_list [5];

   localparam logic [31:0] ST_MASK = 32'h8040_1e80;
   localparam logic [15:0] ADDR    = 16'h1234;

   ccrb_top dut (
      .clock(clock), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_index(cmd_index), .cmd_value(cmd_value), .cmd_drv(cmd_drv),
      .resp_valid(resp_valid), .resp_data(resp_data),
      .relative_bus_address(relative_bus_address), .driver_stage_setting(driver_stage_setting),
      .drv_present(drv_present), .fast_timing_select(fast_timing_select),
      .erase_group_select(erase_group_select), .data_width_select(data_width_select),
      .card_state(card_state)
   );

   ccrb_host host (
      .clock(clock), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_index(cmd_index), .cmd_value(cmd_value), .cmd_drv(cmd_drv),
      .resp_valid(resp_valid), .resp_data(resp_data)
   );

   always #20 clock = ~clock;

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison and report
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   function automatic logic [31:0] sw(input logic [3:0] s, input logic ill, input logic se,
                                      input logic oor);
      return {oor, 8'h00, ill, 9'h000, s, 1'b0, se, 7'h00};
   endfunction

   // Command with expected answer presence and masked status
   task automatic st_cmd(input logic [2:0] op, input logic [15:0] addr, input logic [8:0] idx,
                         input logic [15:0] arg, input logic eg, input logic [31:0] es);
      logic        got;
      logic [31:0] data;
      host.send(op, addr, idx, arg[7:0], arg, got, data);
      check("answer", got, eg);
      if (eg) begin
         check("status", data & ST_MASK, es);
      end
   endtask

   task automatic rd(input logic [8:0] idx, input logic [7:0] exp);
      logic        got;
      logic [31:0] data;
      host.send(ccrb_pkg::OP_READ_BYTE, ADDR, idx, 8'h00, 16'h0000, got, data);
      check("read answer", got, 1'b1);
      check("read byte", data, {24'h00_0000, exp});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clock       = 1'b0;
      rstn        = 1'b0;
      n_fail      = 0;
      comparisons = 0;
      ro_list     = '{ccrb_pkg::IDX_CMD_REV, ccrb_pkg::IDX_ERASED, 9'h0ba, 9'h0b0, 9'h000};
      repeat (12) @(negedge clock);
      rstn = 1'b1;
      check("address", relative_bus_address, ccrb_pkg::ADDR_RESET);
      check("driver", driver_stage_setting, ccrb_pkg::DRV_RESET);
      check("fast", fast_timing_select, 8'h00);
      check("erase", erase_group_select, 8'h00);
      check("state", card_state, ccrb_pkg::ST_IDLE);
      st_cmd(ccrb_pkg::OP_SEND_STATUS, ccrb_pkg::ADDR_RESET, 9'h000, 16'h0000, 0, 0);
      st_cmd(ccrb_pkg::OP_ASSIGN, ccrb_pkg::ADDR_BCAST, 9'h000, 16'h0000, 1,
             sw(ccrb_pkg::ST_IDLE, 1, 0, 0));
      check("address", relative_bus_address, ccrb_pkg::ADDR_RESET);
      st_cmd(ccrb_pkg::OP_ASSIGN, ADDR, 9'h000, 16'h0000, 1, sw(ccrb_pkg::ST_STBY, 0, 0, 0));
      check("address", relative_bus_address, ADDR);
      st_cmd(ccrb_pkg::OP_ASSIGN, 16'h0055, 9'h000, 16'h0000, 0, 0);
      check("address", relative_bus_address, ADDR);
      st_cmd(ccrb_pkg::OP_SEND_STATUS, ccrb_pkg::ADDR_RESET, 9'h000, 16'h0000, 0, 0);
      st_cmd(ccrb_pkg::OP_SEND_STATUS, ADDR, 9'h000, 16'h0000, 1,
             sw(ccrb_pkg::ST_STBY, 0, 0, 0));
      st_cmd(ccrb_pkg::OP_SWITCH, ADDR, ccrb_pkg::IDX_FAST, 16'h0001, 1,
             sw(ccrb_pkg::ST_STBY, 1, 0, 0));
      check("fast", fast_timing_select, 8'h00);
      st_cmd(ccrb_pkg::OP_SELECT, ADDR, 9'h000, 16'h0000, 1, sw(ccrb_pkg::ST_TRAN, 0, 0, 0));
      for (int i = 0; i < ccrb_pkg::NUM_RW; i++) begin
         rd(ccrb_pkg::RW_IDX[i], (i == ccrb_pkg::WIDTH_SLOT) ? 8'h00 : ccrb_pkg::RW_RST[i]);
      end
      for (int i = 0; i < ccrb_pkg::NUM_RW; i++) begin
         v = 8'h10 + 8'(i);
         st_cmd(ccrb_pkg::OP_SWITCH, ADDR, ccrb_pkg::RW_IDX[i], {8'h00, v}, 1,
                sw(ccrb_pkg::ST_TRAN, 0, 0, 0));
         rd(ccrb_pkg::RW_IDX[i], (i == ccrb_pkg::WIDTH_SLOT) ? 8'h00 : v);
      end
      check("fast", fast_timing_select, 8'h12);
      check("erase", erase_group_select, 8'h16);
      check("width", data_width_select, 8'h13);
      st_cmd(ccrb_pkg::OP_SWITCH, 16'h4321, ccrb_pkg::IDX_FAST, 16'h0077, 0, 0);
      check("fast", fast_timing_select, 8'h12);
      foreach (ro_list[i]) begin
         st_cmd(ccrb_pkg::OP_SWITCH, ADDR, ro_list[i], 16'h00ff, 1,
                sw(ccrb_pkg::ST_TRAN, 0, 1, 0));
         rd(ro_list[i], 8'h00);
      end
      st_cmd(ccrb_pkg::OP_SWITCH, ADDR, 9'h12c, 16'h005a, 1, sw(ccrb_pkg::ST_TRAN, 0, 1, 1));
      st_cmd(ccrb_pkg::OP_SWITCH, ADDR, ccrb_pkg::IDX_REV, 16'h005a, 1,
             sw(ccrb_pkg::ST_TRAN, 0, 1, 1));
      rd(ccrb_pkg::IDX_REV, ccrb_pkg::REV_VALUE);
      rd(ccrb_pkg::IDX_STRUCT_VER, ccrb_pkg::STRUCT_VER);
      rd(ccrb_pkg::IDX_CARD_TYPE, ccrb_pkg::CARD_TYPE);
      rd(ccrb_pkg::IDX_BOOT_INFO, ccrb_pkg::BOOT_INFO);
      rd(9'h1ff, 8'h00);
      rd(9'h0c1, 8'h00);
      check("driver flag", drv_present, 1'b1);
      if (drv_present === 1'b1) begin
         st_cmd(ccrb_pkg::OP_SET_DRV, ADDR, 9'h000, 16'h1357, 0, 0);
         check("driver", driver_stage_setting, 16'h1357);
      end
      st_cmd(ccrb_pkg::OP_SELECT, ccrb_pkg::ADDR_BCAST, 9'h000, 16'h0000, 0, 0);
      check("state", card_state, ccrb_pkg::ST_STBY);
      st_cmd(ccrb_pkg::OP_SWITCH, ADDR, ccrb_pkg::IDX_FAST, 16'h0001, 1,
             sw(ccrb_pkg::ST_STBY, 1, 0, 0));
      // Second reset in mid-run
      @(negedge clock);
      rstn = 1'b0;
      @(negedge clock);
      check("address", relative_bus_address, ccrb_pkg::ADDR_RESET);
      check("driver", driver_stage_setting, ccrb_pkg::DRV_RESET);
      check("fast", fast_timing_select, 8'h00);
      check("erase", erase_group_select, 8'h00);
      check("state", card_state, ccrb_pkg::ST_IDLE);
      rstn = 1'b1;
      st_cmd(ccrb_pkg::OP_ASSIGN, ADDR, 9'h000, 16'h0000, 1, sw(ccrb_pkg::ST_STBY, 0, 0, 0));
      check("address", relative_bus_address, ADDR);
      test_done();
   end

endmodule
